/* File: rtl/tamper_and_access_monitor.sv */
// Tamper detection, fraud alarms, no-voltage charge and write protection
`timescale 1ns/1ps
// Notes on behaviour
// - Terminal cover removal logs and sets fraud
// - Refitted terminal cover clears its alarm
// - Command clears terminal cover alarm
// - Main cover removal logs and sets fraud
// - Main cover clear needs admin rights
// - Cover detection works without mains power
// - Magnet over 30s logs and sets fraud
// - Command clears magnetic field alarm
// - Comms module removal logs and sets fraud
// - Command clears comms module alarm
// - Three charge counters, current without voltage
// - Jumper fitted enables parameterization, flashes cursors
// - Jumper removed disables writes to jumper-selected groups
// - Calibration always needs jumper; others selectable
// - Valid password needed for parameter changes
// - Wrong passwords block link until demand reset
// - Four-byte alarm; flags stay until cleared
module tamper_and_access_monitor
    import tamper_pkg::*;
#(
    parameter int unsigned MAG_CYC = MAG_HOLD_CYC,
    parameter int unsigned BLINK_CYC_P = BLINK_CYC
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Tamper sensors, high while condition is present
    input wire logic TCOVER_OPEN_I,
    input wire logic MCOVER_OPEN_I,
    input wire logic MAG_FIELD_I,
    input wire logic COMMS_ABSENT_I,
    // Phase sensing and charge quantum tick
    input wire logic [NUM_PH-1:0] CUR_FLOW_I,
    input wire logic [NUM_PH-1:0] VOLT_OK_I,
    input wire logic AH_TICK_I,
    // Jumper, demand reset and time stamp
    input wire logic JUMPER_I,
    input wire logic DEMAND_RESET_I,
    input wire logic [31:0] TIME_I,
    // AXI4-Lite write address and data
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [7:0] AWADDR_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    // AXI4-Lite write response
    output logic BVALID_O,
    input wire logic BREADY_I,
    output logic [1:0] BRESP_O,
    // AXI4-Lite read
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    input wire logic [7:0] ARADDR_I,
    output logic RVALID_O,
    input wire logic RREADY_I,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    // Log entries, interrupt and indicators
    output log_entry_s LOG_O,
    output logic IRQ_O,
    output logic PARAM_MODE_O,
    output logic CURSOR_FLASH_O,
    output logic COMM_BLOCK_O
);
    // ----------
    // Helpers
    // ----------
    // Merge write data into a word under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ----------
    // State
    // ----------
    logic [NUM_EV-1:0] tamper_q; // Sticky tamper flags
    logic [NUM_EV-1:0] prev_q; // Last sampled sensor levels
    logic [NUM_EV-1:0] pend_q; // Events awaiting a log slot
    logic [30:0] mag_cnt_q; // Magnet persistence counter
    logic [31:0] ah_q [NUM_PH]; // No-voltage charge counters
    logic [31:0] param_q [NUM_PARAM]; // Protected parameter groups
    logic [3:0] jsel_q; // Jumper requirement per group
    logic [1:0] lvl_q; // Granted access level
    logic [2:0] wrong_q; // Consecutive wrong passwords
    logic block_q; // Link blocked
    logic [NUM_INT-1:0] int_stat_q;
    logic [NUM_INT-1:0] int_mask_q;
    logic [23:0] blink_cnt_q;
    logic aw_full_q, w_full_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    log_entry_s log_q;

    // ----------
    // Event detection
    // ----------
    // Nothing here looks at mains state, so openings during an outage are caught
    wire mag_fire = MAG_FIELD_I && (mag_cnt_q == 31'(MAG_CYC)); // Held longer than 30 s
    wire [NUM_EV-1:0] level = {COMMS_ABSENT_I, mag_fire, MCOVER_OPEN_I, TCOVER_OPEN_I};
    // Only the low-to-high transition counts, so a held condition logs once
    wire [NUM_EV-1:0] rise = level & ~prev_q;
    wire tc_refit = prev_q[EV_TCOVER] && !TCOVER_OPEN_I; // Cover placed again
    wire [NUM_EV-1:0] grant = pend_q & (~pend_q + 4'h1); // Lowest pending event

    // ----------
    // Write decode
    // ----------
    wire wr_fire = aw_full_q && w_full_q && !BVALID_O;
    wire wr_param = aw_addr_q[7:4] == PARAM_PAGE;
    wire [1:0] wr_pidx = aw_addr_q[3:2];
    wire authed = lvl_q >= LVL_USER; // Password accepted
    wire jump_need = jsel_q[wr_pidx]; // Bit 0 is pinned high: calibration always needs it
    wire param_ok = authed && (!jump_need || PARAM_MODE_O); // No jumper, no write to a group whose jsel_q bit is set
    wire mc_clr_ok = lvl_q >= LVL_ADMIN; // Main cover clear needs admin
    wire is_cmd = aw_addr_q == ADDR_CMD;
    wire is_acc = aw_addr_q == ADDR_ACCESS;
    wire is_jsel = aw_addr_q == ADDR_JSEL;
    wire is_mask = aw_addr_q == ADDR_INT_MASK;
    wire wr_ok = !block_q && ((is_cmd && (!w_data_q[EV_MCOVER] || mc_clr_ok)) || is_acc ||
        (is_jsel && authed) || is_mask || (wr_param && param_ok)); // Blocked link refuses all
    wire do_wr = wr_fire && wr_ok;
    // Command bits clear alarms
    wire [NUM_EV-1:0] cmd_clr = (do_wr && is_cmd) ? w_data_q[NUM_EV-1:0] : '0;
    wire [NUM_EV-1:0] clr = cmd_clr | {3'h0, tc_refit};
    wire pw_try = do_wr && is_acc;
    wire pw_admin = w_data_q == ADMIN_PW_RST;
    wire pw_user = w_data_q == USER_PW_RST;
    wire pw_bad = pw_try && !pw_admin && !pw_user;
    wire block_set = pw_bad && (wrong_q == WRONG_LIMIT - 3'h1);

    // ----------
    // Read decode
    // ----------
    wire rd_fire = ARVALID_I && ARREADY_O;
    wire [31:0] alarm1 = {18'h0, |tamper_q, 13'h0}; // Fraud bit in 32-bit alarm word
    wire [1:0] rd_idx = ARADDR_I[3:2];
    logic [31:0] rd_data;
    logic rd_hit;
    // Read multiplexer; unmapped offsets read zero with an error
    always_comb begin
        rd_data = 32'h0;
        rd_hit = 1'b1;
        if (ARADDR_I[7:4] == PARAM_PAGE) begin
            rd_data = param_q[rd_idx];
        end else if (ARADDR_I[7:4] == AH_PAGE && rd_idx != 2'h3) begin
            rd_data = ah_q[rd_idx];
        end else begin
            unique case (ARADDR_I)
                ADDR_ALARM1: rd_data = alarm1;
                ADDR_TAMPER: rd_data = {28'h0, tamper_q};
                ADDR_CMD: rd_data = 32'h0;
                ADDR_ACCESS: rd_data = {27'h0, wrong_q, lvl_q};
                ADDR_JSEL: rd_data = {28'h0, jsel_q[3:1], 1'b1};
                ADDR_INT_STAT: rd_data = {27'h0, int_stat_q};
                ADDR_INT_MASK: rd_data = {27'h0, int_mask_q};
                ADDR_STATUS: rd_data = {30'h0, block_q, PARAM_MODE_O};
                default: rd_hit = 1'b0;
            endcase
        end
    end
    wire rd_ok = rd_hit && !block_q;
    wire stat_rc = rd_fire && rd_ok && (ARADDR_I == ADDR_INT_STAT);
    wire [NUM_INT-1:0] int_ev = {block_set, rise};

    // ----------
    // Tamper flags, logging and magnet timer
    // ----------
    // Set wins over clear so an event in the clear cycle survives
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            tamper_q <= '0;
            prev_q <= '0;
            pend_q <= '0;
            mag_cnt_q <= '0;
            log_q <= '0;
        end else begin
            // Flags stay until command or refit
            tamper_q <= rise | (tamper_q & ~clr);
            prev_q <= level;
            pend_q <= (pend_q & ~grant) | rise;
            // One stamped entry per cycle, lowest event first
            log_q.valid <= |pend_q;
            log_q.code <= grant[3] ? 2'h3 : grant[2] ? 2'h2 : grant[1] ? 2'h1 : 2'h0;
            log_q.stamp <= TIME_I;
            // Saturate one past the threshold so the event fires once
            if (!MAG_FIELD_I) begin
                mag_cnt_q <= '0;
            end else if (mag_cnt_q <= 31'(MAG_CYC)) begin
                mag_cnt_q <= mag_cnt_q + 31'h1;
            end
        end
    end

    // ----------
    // No-voltage charge counters
    // ----------
    // Each phase advances only with current and no voltage on it
    always_ff @(posedge CLK_I) begin
        for (int p = 0; p < NUM_PH; p++) begin
            if (!RST_B_I) begin
                ah_q[p] <= '0;
            end else if (AH_TICK_I && CUR_FLOW_I[p] && !VOLT_OK_I[p]) begin
                ah_q[p] <= ah_q[p] + 32'h1;
            end
        end
    end

    // ----------
    // Parameters and configuration
    // ----------
    // Protected groups change only through the gated write path
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            for (int g = 0; g < NUM_PARAM; g++) begin
                param_q[g] <= '0;
            end
            jsel_q <= JSEL_RST;
            int_mask_q <= MASK_RST;
        end else if (do_wr) begin
            if (wr_param) begin
                param_q[wr_pidx] <= merge(param_q[wr_pidx], w_data_q, w_strb_q);
            end
            if (is_jsel && w_strb_q[0]) begin
                jsel_q <= {w_data_q[3:1], 1'b1}; // Selectable groups 1..3
            end
            if (is_mask && w_strb_q[0]) begin
                int_mask_q <= w_data_q[NUM_INT-1:0];
            end
        end
    end

    // ----------
    // Password and link block
    // ----------
    // Demand reset is the only way out of a block
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            lvl_q <= LVL_NONE;
            wrong_q <= '0;
            block_q <= 1'b0;
        end else if (DEMAND_RESET_I) begin
            wrong_q <= '0;
            block_q <= 1'b0;
        end else if (pw_try) begin
            lvl_q <= pw_admin ? LVL_ADMIN : pw_user ? LVL_USER : LVL_NONE;
            wrong_q <= pw_bad ? wrong_q + 3'h1 : 3'h0;
            if (block_set) begin
                block_q <= 1'b1;
                lvl_q <= LVL_NONE;
            end
        end
    end

    // ----------
    // Interrupts
    // ----------
    // Read of the status word clears it; a new event still lands
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            int_stat_q <= '0;
            IRQ_O <= 1'b0;
        end else begin
            int_stat_q <= int_ev | (int_stat_q & ~(stat_rc ? {NUM_INT{1'b1}} : {NUM_INT{1'b0}}));
            IRQ_O <= |(int_stat_q & int_mask_q);
        end
    end

    // ----------
    // Jumper indication
    // ----------
    // Cursor blink from a divider; idle low without the jumper
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            PARAM_MODE_O <= 1'b0;
            CURSOR_FLASH_O <= 1'b0;
            blink_cnt_q <= '0;
        end else begin
            PARAM_MODE_O <= JUMPER_I;
            if (!JUMPER_I) begin
                blink_cnt_q <= '0;
                CURSOR_FLASH_O <= 1'b0;
            end else if (blink_cnt_q == 24'(BLINK_CYC_P - 1)) begin
                blink_cnt_q <= '0;
                CURSOR_FLASH_O <= !CURSOR_FLASH_O;
            end else begin
                blink_cnt_q <= blink_cnt_q + 24'h1;
            end
        end
    end

    // ----------
    // AXI4-Lite write channels
    // ----------
    // Address and data latch independently; one write at a time
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            AWREADY_O <= 1'b0;
            WREADY_O <= 1'b0;
            BVALID_O <= 1'b0;
            BRESP_O <= RESP_OKAY;
        end else begin
            AWREADY_O <= !aw_full_q && !(AWVALID_I && AWREADY_O);
            WREADY_O <= !w_full_q && !(WVALID_I && WREADY_O);
            if (AWVALID_I && AWREADY_O) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= {AWADDR_I[7:2], 2'h0};
            end
            if (WVALID_I && WREADY_O) begin
                w_full_q <= 1'b1;
                w_data_q <= WDATA_I;
                w_strb_q <= WSTRB_I;
            end
            if (wr_fire) begin
                BVALID_O <= 1'b1;
                BRESP_O <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (BVALID_O && BREADY_I) begin
                BVALID_O <= 1'b0;
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                AWREADY_O <= 1'b1;
                WREADY_O <= 1'b1;
            end
        end
    end

    // ----------
    // AXI4-Lite read channels
    // ----------
    // Data is captured at the address handshake
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            ARREADY_O <= 1'b0;
            RVALID_O <= 1'b0;
            RDATA_O <= '0;
            RRESP_O <= RESP_OKAY;
        end else begin
            if (rd_fire) begin
                ARREADY_O <= 1'b0;
                RVALID_O <= 1'b1;
                RDATA_O <= rd_ok ? rd_data : 32'h0;
                RRESP_O <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (RVALID_O && RREADY_I) begin
                RVALID_O <= 1'b0;
                ARREADY_O <= 1'b1;
            end else if (!RVALID_O) begin
                ARREADY_O <= 1'b1;
            end
        end
    end

    // ----------
    // Output drive
    // ----------
    assign LOG_O = log_q;
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            COMM_BLOCK_O <= 1'b0;
        end else begin
            COMM_BLOCK_O <= !DEMAND_RESET_I && (block_q || block_set); // Tracks block_q with no lag
        end
    end
endmodule

/* File: rtl/tamper_pkg.sv */
// Shared constants and types for the tamper and access monitor
package tamper_pkg;
    // ----------
    // Clock and timing
    // ----------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned MAG_HOLD_S = 30;
    localparam int unsigned MAG_HOLD_CYC = MAG_HOLD_S * CLK_HZ;
    localparam int unsigned BLINK_MS = 250;
    localparam int unsigned BLINK_CYC = (BLINK_MS * (CLK_HZ / 1000));
    // ----------
    // Register byte offsets
    // ----------
    localparam logic [7:0] ADDR_ALARM1 = 8'h00;
    localparam logic [7:0] ADDR_TAMPER = 8'h04;
    localparam logic [7:0] ADDR_CMD = 8'h08;
    localparam logic [7:0] ADDR_ACCESS = 8'h0c;
    localparam logic [7:0] ADDR_JSEL = 8'h10;
    localparam logic [7:0] ADDR_INT_STAT = 8'h14;
    localparam logic [7:0] ADDR_INT_MASK = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;
    localparam logic [3:0] PARAM_PAGE = 4'h2;
    localparam logic [3:0] AH_PAGE = 4'h3;
    // ----------
    // Field positions and codes
    // ----------
    localparam int unsigned FRAUD_BIT = 13;
    localparam int unsigned EV_TCOVER = 0;
    localparam int unsigned EV_MCOVER = 1;
    localparam int unsigned EV_MAG = 2;
    localparam int unsigned EV_COMMS = 3;
    localparam int unsigned INT_BLOCK = 4;
    localparam int unsigned NUM_EV = 4;
    localparam int unsigned NUM_INT = 5;
    localparam int unsigned NUM_PH = 3;
    localparam int unsigned NUM_PARAM = 4;
    // ----------
    // Access levels and password limits
    // ----------
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_USER = 2'h1;
    localparam logic [1:0] LVL_ADMIN = 2'h2;
    localparam logic [2:0] WRONG_LIMIT = 3'h3;
    localparam logic [31:0] USER_PW_RST = 32'h1234_5678; // Arbitrary value
    localparam logic [31:0] ADMIN_PW_RST = 32'h8765_4321; // Arbitrary value
    // ----------
    // Reset values and bus answers
    // ----------
    localparam logic [3:0] JSEL_RST = 4'hf;
    localparam logic [NUM_INT-1:0] MASK_RST = 5'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------
    // Carrier types
    // ----------
    typedef struct packed {
        logic valid;
        logic [1:0] code;
        logic [31:0] stamp;
    } log_entry_s;
endpackage

/* File: tb/tamper_properties.sv */
// Concurrent checks on the monitor's ports
`timescale 1ns/1ps
module tamper_properties
    import tamper_pkg::*;
(
    // Clock, reset and sensors
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic TCOVER_OPEN_I,
    input wire logic JUMPER_I,
    // Bus handshakes
    input wire logic AWVALID_I,
    input wire logic AWREADY_O,
    input wire logic WVALID_I,
    input wire logic WREADY_O,
    input wire logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [1:0] BRESP_O,
    input wire logic ARVALID_I,
    input wire logic ARREADY_O,
    input wire logic RVALID_O,
    input wire logic RREADY_I,
    input wire logic [31:0] RDATA_O,
    input wire logic [1:0] RRESP_O,
    // Indicators
    input wire log_entry_s LOG_O,
    input wire logic PARAM_MODE_O,
    input wire logic CURSOR_FLASH_O,
    input wire logic COMM_BLOCK_O
);
    // ----------
    // Helper logic
    // ----------
    logic flash_q; // Last cursor level
    logic [7:0] run_q; // Cycles since the cursor last changed
    // Counts how long the cursor has stood still
    always_ff @(posedge CLK_I) begin
        flash_q <= CURSOR_FLASH_O;
        run_q <= (CURSOR_FLASH_O != flash_q || run_q == 8'hff) ? 8'h00 : run_q + 8'h01;
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    sequence wr_take;
        AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
    endsequence
    sequence rd_take;
        ARVALID_I && ARREADY_O;
    endsequence
    // ----------
    // Assertions
    // ----------
    a_tcover_log: assert property ($rose(TCOVER_OPEN_I) |-> ##2 (LOG_O.valid && LOG_O.code == 2'h0))
        else $error("terminal cover rise not logged");
    a_block_read: assert property (rd_take and COMM_BLOCK_O |=> RRESP_O == RESP_SLVERR && RDATA_O == 32'h0)
        else $error("read served while link blocked");
    a_block_write: assert property (wr_take and COMM_BLOCK_O |-> ##2 (BVALID_O && BRESP_O == RESP_SLVERR))
        else $error("write served while link blocked");
    a_jumper_on: assert property (JUMPER_I [*2] |-> PARAM_MODE_O)
        else $error("parameter mode off with jumper fitted");
    a_jumper_off: assert property (!JUMPER_I [*2] |-> !PARAM_MODE_O && !CURSOR_FLASH_O)
        else $error("parameter mode or flash on without jumper");
    a_cursor_blink: assert property (JUMPER_I [*8] |-> run_q < 8'h06)
        else $error("cursor stopped flashing");
    a_write_resp: assert property (wr_take |=> !BVALID_O ##1 BVALID_O)
        else $error("write answer late or early");
    a_b_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
        else $error("write answer dropped before taken");
    a_ready_back: assert property (BVALID_O && BREADY_I |=> AWREADY_O && WREADY_O)
        else $error("write readies not restored");
endmodule

/* File: tb/axi_host.sv */
// Bus master standing in for the meter host
`timescale 1ns/1ps
module axi_host (
    // Clock
    input wire logic clk_i,
    // Write channels
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [7:0] awaddr_o,
    output logic wvalid_o,
    input wire logic wready_i,
    output logic [31:0] wdata_o,
    output logic [3:0] wstrb_o,
    input wire logic bvalid_i,
    output logic bready_o,
    input wire logic [1:0] bresp_i,
    // Read channels
    output logic arvalid_o,
    input wire logic arready_i,
    output logic [7:0] araddr_o,
    input wire logic rvalid_i,
    output logic rready_o,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i
);
    logic slow = 1'b0; // Delay the answer handshake by one cycle
    initial begin
        {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h00;
        {awaddr_o, araddr_o, wdata_o, wstrb_o} = 52'h0;
    end
    // Address and data go out together; waits are cut only by the bench timeout
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        {awvalid_o, wvalid_o, awaddr_o, wdata_o, wstrb_o} <= {2'h3, a, d, 4'hf};
        bready_o <= !slow;
        do begin
            @(posedge clk_i);
            if (awready_i) awvalid_o <= 1'b0;
            if (wready_i) wvalid_o <= 1'b0;
            if (bvalid_i) bready_o <= 1'b1;
        end while (!(bvalid_i && bready_o));
        r = bresp_i;
        bready_o <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        {arvalid_o, araddr_o} <= {1'b1, a};
        rready_o <= !slow;
        do begin
            @(posedge clk_i);
            if (arready_i) arvalid_o <= 1'b0;
            if (rvalid_i) rready_o <= 1'b1;
        end while (!(rvalid_i && rready_o));
        {d, r} = {rdata_i, rresp_i};
        rready_o <= 1'b0;
    endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the tamper and access monitor
`timescale 1ns/1ps
module tb_top
    import tamper_pkg::*;
;
    logic clk, rst_b, jmp, dmd, tick, irq, pmode, flash, blk;
    logic [3:0] sens; // Terminal, main, magnet, comms
    logic [2:0] cur, volt;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d, pv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    log_entry_s log_e;
    logic [1:0] q[$]; // Logged codes
    logic [31:0] sq[$]; // Logged stamps
    int n_mismatch, total_checks, cyc, seed, fl, ist;
    int ah[3]; // Expected charge counts
    tamper_and_access_monitor #(.MAG_CYC(50), .BLINK_CYC_P(4)) tamper_and_access_monitor_i (
        .CLK_I(clk), .RST_B_I(rst_b), .TCOVER_OPEN_I(sens[0]), .MCOVER_OPEN_I(sens[1]),
        .MAG_FIELD_I(sens[2]), .COMMS_ABSENT_I(sens[3]), .CUR_FLOW_I(cur), .VOLT_OK_I(volt),
        .AH_TICK_I(tick), .JUMPER_I(jmp), .DEMAND_RESET_I(dmd), .TIME_I(cyc[31:0]),
        .AWVALID_I(awvalid), .AWREADY_O(awready), .AWADDR_I(awaddr), .WVALID_I(wvalid),
        .WREADY_O(wready), .WDATA_I(wdata), .WSTRB_I(wstrb), .BVALID_O(bvalid), .BREADY_I(bready),
        .BRESP_O(bresp), .ARVALID_I(arvalid), .ARREADY_O(arready), .ARADDR_I(araddr),
        .RVALID_O(rvalid), .RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rresp), .LOG_O(log_e),
        .IRQ_O(irq), .PARAM_MODE_O(pmode), .CURSOR_FLASH_O(flash), .COMM_BLOCK_O(blk));
    axi_host axi_host_i (
        .clk_i(clk), .awvalid_o(awvalid), .awready_i(awready), .awaddr_o(awaddr), .wvalid_o(wvalid),
        .wready_i(wready), .wdata_o(wdata), .wstrb_o(wstrb), .bvalid_i(bvalid), .bready_o(bready),
        .bresp_i(bresp), .arvalid_o(arvalid), .arready_i(arready), .araddr_o(araddr),
        .rvalid_i(rvalid), .rready_o(rready), .rdata_i(rdata), .rresp_i(rresp));
    // ----------
    // Checking helpers
    // ----------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        axi_host_i.rd(a, d, r);
        chk("read data", d, e);
        chk("read resp", {30'h0, r}, {30'h0, er});
    endtask
    task automatic wrc(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        axi_host_i.wr(a, v, r);
        chk("write resp", {30'h0, r}, {30'h0, er});
    endtask
    task automatic flags;
        rdc(ADDR_TAMPER, 32'(fl), RESP_OKAY);
        rdc(ADDR_ALARM1, {18'h0, fl != 0, 13'h0}, RESP_OKAY);
    endtask
    // Raise one sensor and hold it; exactly one entry must come out
    task automatic ev(input int k, input int hold);
        int t0;
        sens[k] <= 1'b1;
        t0 = cyc;
        repeat (hold) @(posedge clk);
        fl |= 1 << k;
        ist |= 1 << k;
        chk("log count", q.size(), 1);
        chk("log code", {30'h0, q[0]}, 32'(k));
        chk("log stamp", 32'(sq[0] - t0 <= hold), 1);
        q.delete();
        sq.delete();
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Clock and reference model of logs and charge counters
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (log_e.valid === 1'b1) begin
            q.push_back(log_e.code);
            sq.push_back(log_e.stamp);
        end
        if (rst_b && tick) for (int p = 0; p < 3; p++) if (cur[p] && !volt[p]) ah[p]++;
        if (cyc > 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // ----------
    // Main sequence
    // ----------
    initial begin
        {rst_b, jmp, dmd, tick, sens, cur, volt} = 14'h0;
        {cyc, fl, ist, n_mismatch, total_checks} = 0;
        seed = 32'ha994;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        flags();
        rdc(ADDR_INT_MASK, 32'h0, RESP_OKAY);
        rdc(ADDR_STATUS, 32'h0, RESP_OKAY);
        rdc(8'h40, 32'h0, RESP_SLVERR);
        wrc(ADDR_INT_MASK, 32'h1f, RESP_OKAY);
        ev(0, 12);
        flags();
        chk("irq", {31'h0, irq}, 1);
        sens[0] <= 1'b0;
        repeat (3) @(posedge clk);
        fl = 0;
        flags();
        ev(0, 12);
        wrc(ADDR_CMD, 32'h1, RESP_OKAY);
        fl = 0;
        flags();
        sens[0] <= 1'b0;
        axi_host_i.slow = 1'b1;
        ev(1, 12);
        sens[1] <= 1'b0;
        wrc(ADDR_CMD, 32'h2, RESP_SLVERR);
        flags();
        axi_host_i.slow = 1'b0;
        sens[2] <= 1'b1;
        repeat (50) @(posedge clk);
        sens[2] <= 1'b0;
        repeat (6) @(posedge clk);
        chk("short magnet", q.size(), 0);
        ev(2, 60);
        sens[2] <= 1'b0;
        wrc(ADDR_CMD, 32'h4, RESP_OKAY);
        fl &= ~4;
        flags();
        rdc(ADDR_INT_STAT, 32'(ist), RESP_OKAY);
        wrc(ADDR_INT_MASK, 32'h0, RESP_OKAY);
        ev(3, 12);
        chk("irq masked", {31'h0, irq}, 0);
        wrc(ADDR_INT_MASK, 32'h8, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("irq unmasked", {31'h0, irq}, 1);
        rdc(ADDR_INT_STAT, 32'h8, RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("irq cleared", {31'h0, irq}, 0);
        ist = 0;
        sens[3] <= 1'b0;
        wrc(ADDR_CMD, 32'h8, RESP_OKAY);
        fl &= ~8;
        flags();
        $display("tamper tests done");
        repeat (200) @(posedge clk) {cur, volt, tick} <= 7'($random(seed));
        tick <= 1'b0;
        repeat (2) @(posedge clk);
        for (int p = 0; p < 3; p++) rdc(8'h30 + 8'(4 * p), 32'(ah[p]), RESP_OKAY);
        pv = $random(seed);
        wrc(8'h24, pv, RESP_SLVERR);
        wrc(ADDR_ACCESS, USER_PW_RST, RESP_OKAY);
        rdc(ADDR_ACCESS, 32'h1, RESP_OKAY);
        wrc(8'h24, pv, RESP_SLVERR);
        rdc(ADDR_JSEL, {28'h0, JSEL_RST}, RESP_OKAY);
        wrc(ADDR_JSEL, 32'h0, RESP_OKAY);
        rdc(ADDR_JSEL, 32'h1, RESP_OKAY);
        wrc(8'h24, pv, RESP_OKAY);
        rdc(8'h24, pv, RESP_OKAY);
        wrc(8'h20, ~pv, RESP_SLVERR);
        jmp <= 1'b1;
        repeat (12) @(posedge clk);
        rdc(ADDR_STATUS, 32'h1, RESP_OKAY);
        wrc(8'h20, ~pv, RESP_OKAY);
        jmp <= 1'b0;
        repeat (3) @(posedge clk);
        wrc(8'h20, pv, RESP_SLVERR);
        rdc(8'h20, ~pv, RESP_OKAY);
        wrc(ADDR_ACCESS, ADMIN_PW_RST, RESP_OKAY);
        wrc(ADDR_CMD, 32'h2, RESP_OKAY);
        fl = 0;
        flags();
        $display("access tests done");
        repeat (3) axi_host_i.wr(ADDR_ACCESS, 32'h0, r);
        repeat (3) @(posedge clk);
        chk("blocked", {31'h0, blk}, 1);
        rdc(ADDR_ALARM1, 32'h0, RESP_SLVERR);
        wrc(ADDR_ACCESS, ADMIN_PW_RST, RESP_SLVERR);
        dmd <= 1'b1;
        @(posedge clk) dmd <= 1'b0;
        repeat (3) @(posedge clk);
        chk("unblocked", {31'h0, blk}, 0);
        rdc(ADDR_ACCESS, 32'h0, RESP_OKAY);
        rdc(ADDR_INT_STAT, 32'h10, RESP_OKAY);
        $display("block tests done");
        tally_and_finish();
    end
endmodule
bind tamper_and_access_monitor tamper_properties tamper_properties_i (.*);
